// ==== core/asp_defines.svh ====
/*
 * Register selects, field positions, reset values and bit timing of the serial port.
 * Assumes it is included by bare name from the serial port source and the bench.
 */
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
`define ASP_REG_DATA   3'h0
`define ASP_REG_FMT    3'h1
`define ASP_REG_DIVL   3'h2
`define ASP_REG_DIVH   3'h3
`define ASP_REG_STAT   3'h4
`define ASP_F_LEN      1:0
`define ASP_F_STOP     3:2
`define ASP_F_PEN      4
`define ASP_F_EVEN     5
`define ASP_F_BSEL     6
`define ASP_F_TXEN     7
`define ASP_FMT_RST    8'h83
`define ASP_DIV_RST    16'h0001
`define ASP_STOP_ONE   2'h0
`define ASP_STOP_HALF  2'h1
`define ASP_T_BIT      6'h10
`define ASP_T_STOP15   6'h18
`define ASP_T_STOP2    6'h20
`define ASP_T_MID      6'h07
`define ASP_LEN_BASE   3'h4
`define ASP_WIDTH      8
`define ASP_DEPTH      32
`endif

// ==== core/asp_pkg.sv ====
/*
 * Types of the serial port: transmitter and receiver states.
 * Assumes nothing beyond the defines header.
 */
package asp_pkg;
    typedef enum logic [4:0] {
        ASP_TX_IDLE  = 5'b00001,
        ASP_TX_START = 5'b00010,
        ASP_TX_DATA  = 5'b00100,
        ASP_TX_PAR   = 5'b01000,
        ASP_TX_STOP  = 5'b10000
    } asp_tx_state_t;
    typedef enum logic [4:0] {
        ASP_RX_IDLE  = 5'b00001,
        ASP_RX_START = 5'b00010,
        ASP_RX_DATA  = 5'b00100,
        ASP_RX_PAR   = 5'b01000,
        ASP_RX_STOP  = 5'b10000
    } asp_rx_state_t;
endpackage

// ==== core/asp_serial_port.sv ====
/*
 * Asynchronous serial port with parallel host bus, baud generator and a transmit FIFO.
 * Assumes all inputs are synchronous to CLK and the data bus wire is resolved outside.
 */
`include "asp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module asp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;

    assign out_valid = (wp_r != rp_r);
    assign in_ready  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
    assign out_data  = mem[rp_r[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
            mem[wp_r[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
                wp_r <= wp_r + 1'b1;
            if (out_valid && out_ready)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule

module asp_serial_port (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // Host bus selects and strobes
    input  wire logic       CHIP_SELECT_FIRST,
    input  wire logic       CHIP_SELECT_SECOND,
    input  wire logic       CHIP_SELECT_THIRD_N,
    input  wire logic       READ_STROBE_PAIR_HI,
    input  wire logic       READ_STROBE_PAIR_N,
    input  wire logic       WRITE_STROBE_PAIR_HI,
    input  wire logic       WRITE_STROBE_PAIR_N,
    input  wire logic [2:0] REGISTER_SELECT_LINES,
    // Host data bus, split three ways
    input  wire logic [7:0] HOST_DATA_BUS_IN,
    output logic      [7:0] HOST_DATA_BUS_OUT,
    output logic            HOST_DATA_BUS_OE,
    // Serial line
    input  wire logic       SERIAL_IN,
    output logic            SERIAL_OUT,
    output logic            BAUD_CLOCK_OUT
);
    logic [7:0]  fmt_r;
    logic [15:0] div_r;
    logic [15:0] bcnt_r;
    logic        tick_r;
    logic        rd_prev_r;
    logic        wr_prev_r;
    logic        sel;
    logic        rd_act;
    logic        wr_act;
    logic        rd_start;
    logic        wr_start;
    logic [7:0]  len_mask;
    logic [2:0]  last_idx;
    logic [5:0]  stop_ticks;
    logic        tx_en;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_ready;
    logic        fifo_pop;
    logic        push;

    asp_pkg::asp_tx_state_t tx_st_r;
    logic [5:0]  tx_cnt_r;
    logic [2:0]  tx_idx_r;
    logic [7:0]  tx_sh_r;
    logic        tx_par_r;

    asp_pkg::asp_rx_state_t rx_st_r;
    logic [5:0]  rx_cnt_r;
    logic [2:0]  rx_idx_r;
    logic [7:0]  rx_sh_r;
    logic [7:0]  rx_word_r;
    logic        rx_rdy_r;
    logic        rx_ovr_r;
    logic        rx_perr_r;
    logic        rx_ferr_r;
    logic        rx_stop_ok;

    // Both strobe pairs are OR-ed; the host keeps the unused one of each pair idle.
    assign sel      = CHIP_SELECT_FIRST & CHIP_SELECT_SECOND & ~CHIP_SELECT_THIRD_N;
    assign rd_act   = sel & (READ_STROBE_PAIR_HI | ~READ_STROBE_PAIR_N);
    assign wr_act   = sel & (WRITE_STROBE_PAIR_HI | ~WRITE_STROBE_PAIR_N);
    assign rd_start = rd_act & ~rd_prev_r;
    assign wr_start = wr_act & ~wr_prev_r;
    assign last_idx = fmt_r[`ASP_F_LEN] + `ASP_LEN_BASE;
    assign len_mask = 8'hff >> (3'h7 - last_idx);
    assign tx_en    = fmt_r[`ASP_F_TXEN];
    assign stop_ticks = (fmt_r[`ASP_F_STOP] == `ASP_STOP_ONE) ? `ASP_T_BIT :
                        (fmt_r[`ASP_F_STOP] == `ASP_STOP_HALF) ? `ASP_T_STOP15 :
                        `ASP_T_STOP2;
    assign push     = wr_start && (REGISTER_SELECT_LINES == `ASP_REG_DATA);
    assign fifo_pop = tx_en && (tx_st_r == asp_pkg::ASP_TX_IDLE) && fifo_valid;
    assign rx_stop_ok = SERIAL_IN;

    // A full FIFO refuses the write; software checks the full flag before writing.
    asp_fifo #(.W(`ASP_WIDTH), .D(`ASP_DEPTH)) u_txq (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_data   (HOST_DATA_BUS_IN & len_mask),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            fmt_r     <= `ASP_FMT_RST;
            div_r     <= `ASP_DIV_RST;
        end
        else
        begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            if (wr_start)
            begin
                case (REGISTER_SELECT_LINES)
                    `ASP_REG_FMT:  fmt_r <= HOST_DATA_BUS_IN;
                    `ASP_REG_DIVL: div_r[7:0] <= HOST_DATA_BUS_IN;
                    `ASP_REG_DIVH: div_r[15:8] <= HOST_DATA_BUS_IN;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            HOST_DATA_BUS_OE  <= 1'b0;
            HOST_DATA_BUS_OUT <= 8'h00;
        end
        else
        begin
            HOST_DATA_BUS_OE <= rd_act;
            case (REGISTER_SELECT_LINES)
                `ASP_REG_DATA: HOST_DATA_BUS_OUT <= rx_word_r & len_mask;
                `ASP_REG_FMT:  HOST_DATA_BUS_OUT <= fmt_r;
                `ASP_REG_DIVL: HOST_DATA_BUS_OUT <= div_r[7:0];
                `ASP_REG_DIVH: HOST_DATA_BUS_OUT <= div_r[15:8];
                `ASP_REG_STAT: HOST_DATA_BUS_OUT <= {1'b0, tx_st_r == asp_pkg::ASP_TX_IDLE,
                    ~fifo_ready, ~fifo_valid, rx_ferr_r, rx_perr_r, rx_ovr_r, rx_rdy_r};
                default:       HOST_DATA_BUS_OUT <= 8'h00;
            endcase
        end
    end

    // A zero divisor stops the baud clock rather than counting through 65536.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            bcnt_r <= 16'h0000;
            tick_r <= 1'b0;
            BAUD_CLOCK_OUT <= 1'b0;
        end
        else
        begin
            tick_r <= 1'b0;
            if (div_r == 16'h0000)
                bcnt_r <= 16'h0000;
            else if (bcnt_r + 16'h0001 >= div_r)
            begin
                bcnt_r <= 16'h0000;
                tick_r <= 1'b1;
            end
            else
                bcnt_r <= bcnt_r + 16'h0001;
            // The oscillator copy is half rate: a flop cannot echo its own clock.
            BAUD_CLOCK_OUT <= fmt_r[`ASP_F_BSEL] ? tick_r : ~BAUD_CLOCK_OUT;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            tx_st_r  <= asp_pkg::ASP_TX_IDLE;
            tx_cnt_r <= 6'h00;
            tx_idx_r <= 3'h0;
            tx_sh_r  <= 8'h00;
            tx_par_r <= 1'b0;
            SERIAL_OUT <= 1'b1;
        end
        else if (!tx_en)
        begin
            tx_st_r    <= asp_pkg::ASP_TX_IDLE;
            SERIAL_OUT <= 1'b1;
        end
        else if (fifo_pop)
        begin
            tx_st_r    <= asp_pkg::ASP_TX_START;
            tx_cnt_r   <= 6'h00;
            tx_idx_r   <= 3'h0;
            tx_sh_r    <= fifo_data & len_mask;
            tx_par_r   <= ^(fifo_data & len_mask) ^ ~fmt_r[`ASP_F_EVEN];
            SERIAL_OUT <= 1'b0;
        end
        else if (tick_r && tx_st_r != asp_pkg::ASP_TX_IDLE)
        begin
            if (tx_cnt_r + 6'h01 < ((tx_st_r == asp_pkg::ASP_TX_STOP) ? stop_ticks : `ASP_T_BIT))
                tx_cnt_r <= tx_cnt_r + 6'h01;
            else
            begin
                tx_cnt_r <= 6'h00;
                case (tx_st_r)
                    asp_pkg::ASP_TX_START:
                    begin
                        tx_st_r    <= asp_pkg::ASP_TX_DATA;
                        SERIAL_OUT <= tx_sh_r[0];
                    end
                    asp_pkg::ASP_TX_DATA:
                    begin
                        if (tx_idx_r == last_idx)
                        begin
                            tx_st_r    <= fmt_r[`ASP_F_PEN] ? asp_pkg::ASP_TX_PAR
                                                            : asp_pkg::ASP_TX_STOP;
                            SERIAL_OUT <= fmt_r[`ASP_F_PEN] ? tx_par_r : 1'b1;
                        end
                        else
                        begin
                            tx_idx_r   <= tx_idx_r + 3'h1;
                            tx_sh_r    <= tx_sh_r >> 1;
                            SERIAL_OUT <= tx_sh_r[1];
                        end
                    end
                    asp_pkg::ASP_TX_PAR:
                    begin
                        tx_st_r    <= asp_pkg::ASP_TX_STOP;
                        SERIAL_OUT <= 1'b1;
                    end
                    default:
                    begin
                        tx_st_r    <= asp_pkg::ASP_TX_IDLE;
                        SERIAL_OUT <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rx_st_r  <= asp_pkg::ASP_RX_IDLE;
            rx_cnt_r <= 6'h00;
            rx_idx_r <= 3'h0;
            rx_sh_r  <= 8'h00;
        end
        else if (tick_r)
        begin
            rx_cnt_r <= rx_cnt_r + 6'h01;
            case (rx_st_r)
                asp_pkg::ASP_RX_IDLE:
                begin
                    rx_cnt_r <= 6'h00;
                    rx_idx_r <= 3'h0;
                    rx_sh_r  <= 8'h00;
                    if (!SERIAL_IN)
                        rx_st_r <= asp_pkg::ASP_RX_START;
                end
                asp_pkg::ASP_RX_START:
                begin
                    if (rx_cnt_r == `ASP_T_MID)
                    begin
                        rx_cnt_r <= 6'h00;
                        rx_st_r  <= SERIAL_IN ? asp_pkg::ASP_RX_IDLE : asp_pkg::ASP_RX_DATA;
                    end
                end
                asp_pkg::ASP_RX_DATA:
                begin
                    if (rx_cnt_r == `ASP_T_BIT - 6'h01)
                    begin
                        rx_cnt_r          <= 6'h00;
                        rx_sh_r[rx_idx_r] <= SERIAL_IN;
                        rx_idx_r          <= rx_idx_r + 3'h1;
                        if (rx_idx_r == last_idx)
                            rx_st_r <= fmt_r[`ASP_F_PEN] ? asp_pkg::ASP_RX_PAR
                                                         : asp_pkg::ASP_RX_STOP;
                    end
                end
                asp_pkg::ASP_RX_PAR:
                begin
                    if (rx_cnt_r == `ASP_T_BIT - 6'h01)
                    begin
                        rx_cnt_r <= 6'h00;
                        rx_st_r  <= asp_pkg::ASP_RX_STOP;
                    end
                end
                default:
                begin
                    if (rx_cnt_r == `ASP_T_BIT - 6'h01)
                        rx_st_r <= asp_pkg::ASP_RX_IDLE;
                end
            endcase
        end
    end

    // Flags set by the receiver win over a clearing read in the same cycle.
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rx_word_r <= 8'h00;
            rx_rdy_r  <= 1'b0;
            rx_ovr_r  <= 1'b0;
            rx_perr_r <= 1'b0;
            rx_ferr_r <= 1'b0;
        end
        else
        begin
            if (rd_start && REGISTER_SELECT_LINES == `ASP_REG_DATA)
                rx_rdy_r <= 1'b0;
            if (rd_start && REGISTER_SELECT_LINES == `ASP_REG_STAT)
            begin
                rx_ovr_r  <= 1'b0;
                rx_perr_r <= 1'b0;
                rx_ferr_r <= 1'b0;
            end
            if (tick_r && rx_st_r == asp_pkg::ASP_RX_PAR && rx_cnt_r == `ASP_T_BIT - 6'h01
                && (SERIAL_IN != (^rx_sh_r ^ ~fmt_r[`ASP_F_EVEN])))
                rx_perr_r <= 1'b1;
            if (tick_r && rx_st_r == asp_pkg::ASP_RX_STOP && rx_cnt_r == `ASP_T_BIT - 6'h01)
            begin
                rx_word_r <= rx_sh_r & len_mask;
                rx_rdy_r  <= 1'b1;
                if (rx_rdy_r)
                    rx_ovr_r <= 1'b1;
                if (!rx_stop_ok)
                    rx_ferr_r <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_load;
        fifo_pop;
    endsequence
    sequence s_start_bit;
        !SERIAL_OUT && tx_st_r == asp_pkg::ASP_TX_START;
    endsequence

    property p_start_bit;
        s_load |=> s_start_bit;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit after load");

    property p_mark_off;
        !tx_en |=> SERIAL_OUT;
    endproperty
    a_mark_off: assert property (p_mark_off) else $error("line not mark when off");

    property p_mark_idle;
        tx_st_r == asp_pkg::ASP_TX_IDLE && !fifo_pop |-> SERIAL_OUT;
    endproperty
    a_mark_idle: assert property (p_mark_idle) else $error("line not mark when idle");

    property p_bus_quiet;
        !sel |=> !HOST_DATA_BUS_OE;
    endproperty
    a_bus_quiet: assert property (p_bus_quiet) else $error("bus driven unselected");

    // A shorter length set after a word arrived must still read back with zero high bits.
    property p_high_zero;
        rd_act && REGISTER_SELECT_LINES == `ASP_REG_DATA
            |=> (HOST_DATA_BUS_OUT & ~$past(len_mask)) == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("unused bits not zero");

    property p_tick_gap;
        tick_r && div_r > 16'h0001 && $stable(div_r) |=> !tick_r;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("baud tick too early");

    property p_false_start;
        tick_r && rx_st_r == asp_pkg::ASP_RX_START && rx_cnt_r == `ASP_T_MID && SERIAL_IN
            |=> rx_st_r == asp_pkg::ASP_RX_IDLE;
    endproperty
    a_false_start: assert property (p_false_start) else $error("glitch taken as start");

    property p_read_data;
        rd_act && REGISTER_SELECT_LINES == `ASP_REG_FMT && $stable(fmt_r)
            |=> HOST_DATA_BUS_OE && HOST_DATA_BUS_OUT == fmt_r;
    endproperty
    a_read_data: assert property (p_read_data) else $error("wrong read data");

    property p_baud16;
        fmt_r[`ASP_F_BSEL] && tick_r |=> BAUD_CLOCK_OUT;
    endproperty
    a_baud16: assert property (p_baud16) else $error("baud out missed tick");
endmodule

`default_nettype wire

// ==== tb/asp_line_model.sv ====
/*
 * Behavioural model of the remote serial line: sends and receives frames.
 * Assumes the bit time is a fixed number of clk cycles set by bit_cyc.
 */
`timescale 1ns/1ps
`default_nettype none

module asp_line_model (
    // Clock
    input  wire logic clk,
    // Serial line
    input  wire logic serial_out,
    output logic      serial_in
);
    int bit_cyc = 16;

    initial serial_in = 1'b1;

    task automatic put(input logic b);
        serial_in <= b;
        repeat (bit_cyc) @(posedge clk);
    endtask

    // A low stop bit lets the bench provoke a framing error on purpose.
    task automatic send(input logic [7:0] d, input int n, input logic pen, input logic even,
                        input logic stop);
        logic [7:0] m;
        int         k;
        m = 8'hff >> (8 - n);
        @(posedge clk);
        put(1'b0);
        for (k = 0; k < n; k++) put(d[k]);
        if (pen) put(^(d & m) ^ ~even);
        put(stop);
        put(1'b1);
    endtask

    task automatic recv(output logic [7:0] d, input int n, input logic pen, input logic even,
                        output logic ok, output realtime t);
        int k;
        d = 8'h00;
        ok = 1'b1;
        wait (serial_out === 1'b0);
        t = $realtime;
        repeat (bit_cyc / 2) @(posedge clk);
        if (serial_out !== 1'b0) ok = 1'b0;
        for (k = 0; k < n; k++)
        begin
            repeat (bit_cyc) @(posedge clk);
            d[k] = serial_out;
        end
        if (pen)
        begin
            repeat (bit_cyc) @(posedge clk);
            if (serial_out !== (^d ^ ~even)) ok = 1'b0;
        end
        repeat (bit_cyc) @(posedge clk);
        if (serial_out !== 1'b1) ok = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== tb/tb_async_serial_host_port.sv ====
/*
 * Self-checking bench of the serial port: host bus, framing, baud output, FIFO.
 * Assumes the design package, defines header and the line model are compiled first.
 */
`include "asp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_async_serial_host_port;
    logic       clk;
    logic       sys_rst;
    logic       cs_a;
    logic       cs_b;
    logic       cs_c_n;
    logic       rd_hi;
    logic       rd_n;
    logic       wr_hi;
    logic       wr_n;
    logic [2:0] rsel;
    logic [7:0] din;
    logic [7:0] dout;
    logic       doe;
    logic       ser_in;
    logic       ser_out;
    logic       baud;
    int         n_fail;
    int         checks;

    asp_serial_port i_asp_serial_port (
        .CLK(clk), .SYS_RST(sys_rst),
        .CHIP_SELECT_FIRST(cs_a), .CHIP_SELECT_SECOND(cs_b), .CHIP_SELECT_THIRD_N(cs_c_n),
        .READ_STROBE_PAIR_HI(rd_hi), .READ_STROBE_PAIR_N(rd_n),
        .WRITE_STROBE_PAIR_HI(wr_hi), .WRITE_STROBE_PAIR_N(wr_n),
        .REGISTER_SELECT_LINES(rsel), .HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout),
        .HOST_DATA_BUS_OE(doe), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .BAUD_CLOCK_OUT(baud)
    );

    asp_line_model i_asp_line_model (
        .clk(clk), .serial_out(ser_out), .serial_in(ser_in)
    );

    always #12.5 clk = ~clk;

    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Only one strobe of each pair moves; the other rests at its inactive level.
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic lo);
        @(posedge clk);
        rsel <= a;
        din <= d;
        if (lo) wr_n <= 1'b0; else wr_hi <= 1'b1;
        repeat (2) @(posedge clk);
        wr_n <= 1'b1;
        wr_hi <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d, input logic lo);
        int k;
        @(posedge clk);
        rsel <= a;
        if (lo) rd_n <= 1'b0; else rd_hi <= 1'b1;
        for (k = 0; k < 8 && doe !== 1'b1; k++) @(posedge clk);
        chk("read answer", 16'h1, {15'h0, doe});
        d = dout;
        rd_n <= 1'b1;
        rd_hi <= 1'b0;
        repeat (3) @(posedge clk);
        chk("bus released", 16'h0, {15'h0, doe});
    endtask

    task automatic t_reset;
        logic [7:0] d;
        chk("mark at reset", 16'h1, {15'h0, ser_out});
        rd(`ASP_REG_FMT, d, 1'b0);
        chk("fmt reset", `ASP_FMT_RST, d);
        rd(`ASP_REG_DIVL, d, 1'b1);
        chk("div low reset", 16'h01, d);
        rd(`ASP_REG_DIVH, d, 1'b0);
        chk("div high reset", 16'h00, d);
        rd(`ASP_REG_STAT, d, 1'b1);
        chk("status reset", 16'h50, d);
        rd(3'h7, d, 1'b0);
        chk("unmapped read", 16'h00, d);
    endtask

    task automatic t_select;
        logic [7:0] d;
        int         k;
        int         k2;
        for (k = 0; k < 3; k++)
        begin
            @(posedge clk);
            cs_a <= (k != 0);
            cs_b <= (k != 1);
            cs_c_n <= (k == 2);
            wr(`ASP_REG_FMT, 8'h00, k[0]);
            rd_hi <= 1'b1;
            for (k2 = 0; k2 < 4; k2++)
            begin
                @(posedge clk);
                chk("oe while unselected", 16'h0, {15'h0, doe});
            end
            rd_hi <= 1'b0;
            cs_a <= 1'b1;
            cs_b <= 1'b1;
            cs_c_n <= 1'b0;
            rd(`ASP_REG_FMT, d, 1'b1);
            chk("fmt kept", `ASP_FMT_RST, d);
        end
    endtask

    task automatic t_tx_len;
        logic [7:0] d;
        logic [7:0] v;
        logic       ok;
        realtime    t;
        int         n;
        for (n = 5; n <= 8; n++)
        begin
            v = 8'hff & ~(8'h01 << n);
            wr(`ASP_REG_FMT, 8'h80 | 8'(n - 5), n[0]);
            wr(`ASP_REG_DATA, v, ~n[0]);
            i_asp_line_model.recv(d, n, 1'b0, 1'b0, ok, t);
            chk("tx frame", 16'h1, {15'h0, ok});
            chk("tx data", v & (8'hff >> (8 - n)), d);
        end
    endtask

    task automatic t_stop_parity;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] f;
        logic       ok1;
        logic       ok2;
        realtime    t1;
        realtime    t2;
        int         s;
        int         p;
        int         e;
        for (s = 0; s < 3; s++)
        begin
            // Both words wait with the transmitter off, so the first frame starts at a known edge.
            f = 8'h13 | 8'(s << 2) | (s == 1 ? 8'h20 : 8'h00);
            wr(`ASP_REG_FMT, f, 1'b0);
            wr(`ASP_REG_DATA, 8'h1e, 1'b1);
            wr(`ASP_REG_DATA, 8'h8d, 1'b0);
            wr(`ASP_REG_FMT, f | 8'h80, 1'b1);
            i_asp_line_model.recv(d1, 8, 1'b1, s == 1, ok1, t1);
            i_asp_line_model.recv(d2, 8, 1'b1, s == 1, ok2, t2);
            chk("parity frames", 16'h3, {14'h0, ok1, ok2});
            chk("frame words", 16'h1e8d, {d1, d2});
            p = int'((t2 - t1) / 25.0);
            e = 160 + 16 + 8 * s;
            chk("stop length", 16'h1, {15'h0, p >= e && p <= e + 2});
        end
    endtask

    task automatic t_rx;
        logic [7:0] d;
        wr(`ASP_REG_FMT, 8'h92, 1'b0);
        i_asp_line_model.send(8'hda, 7, 1'b1, 1'b0, 1'b1);
        rd(`ASP_REG_STAT, d, 1'b1);
        chk("rx ready", 16'h01, d & 8'h0f);
        rd(`ASP_REG_DATA, d, 1'b0);
        chk("rx data", 16'h5a, d);
        i_asp_line_model.send(8'h11, 7, 1'b1, 1'b0, 1'b1);
        i_asp_line_model.send(8'h22, 7, 1'b1, 1'b0, 1'b1);
        rd(`ASP_REG_STAT, d, 1'b0);
        chk("rx overrun", 16'h03, d & 8'h0f);
        rd(`ASP_REG_DATA, d, 1'b1);
        chk("rx last word", 16'h22, d);
        i_asp_line_model.send(8'h33, 7, 1'b1, 1'b1, 1'b1);
        rd(`ASP_REG_STAT, d, 1'b1);
        chk("rx parity error", 16'h05, d & 8'h0f);
        rd(`ASP_REG_DATA, d, 1'b0);
        i_asp_line_model.send(8'h44, 7, 1'b1, 1'b0, 1'b0);
        rd(`ASP_REG_STAT, d, 1'b0);
        chk("rx framing error", 16'h09, d & 8'h0f);
        repeat (400) @(posedge clk);
        rd(`ASP_REG_STAT, d, 1'b1);
        rd(`ASP_REG_DATA, d, 1'b1);
    endtask

    task automatic t_baud;
        logic [7:0] d;
        logic       pv;
        int         cnt;
        int         k;
        wr(`ASP_REG_DIVL, 8'h03, 1'b1);
        wr(`ASP_REG_FMT, 8'hc3, 1'b0);
        repeat (4) @(posedge clk);
        cnt = 0;
        for (k = 0; k < 300; k++)
        begin
            @(posedge clk);
            cnt += (baud === 1'b1);
        end
        chk("baud pulses", 16'd100, 16'(cnt));
        wr(`ASP_REG_FMT, 8'h83, 1'b1);
        repeat (3) @(posedge clk);
        cnt = 0;
        pv = baud;
        for (k = 0; k < 8; k++)
        begin
            @(posedge clk);
            cnt += (baud !== pv);
            pv = baud;
        end
        chk("osc toggles", 16'd8, 16'(cnt));
        wr(`ASP_REG_DIVH, 8'h01, 1'b0);
        rd(`ASP_REG_DIVH, d, 1'b0);
        chk("div high", 16'h01, d);
        wr(`ASP_REG_DIVH, 8'h00, 1'b1);
        wr(`ASP_REG_DIVL, 8'h01, 1'b0);
    endtask

    // With the transmitter off the FIFO fills to 32 words and the last two writes are dropped.
    task automatic t_fifo;
        logic [7:0] d;
        logic       ok;
        realtime    t;
        int         k;
        wr(`ASP_REG_FMT, 8'h03, 1'b0);
        for (k = 0; k < 34; k++) wr(`ASP_REG_DATA, 8'(k), k[0]);
        rd(`ASP_REG_STAT, d, 1'b0);
        chk("fifo full", 16'h20, d & 8'h30);
        wr(`ASP_REG_FMT, 8'h83, 1'b1);
        for (k = 0; k < 32; k++)
        begin
            i_asp_line_model.recv(d, 8, 1'b0, 1'b0, ok, t);
            chk("fifo word", 16'(k), d);
        end
        repeat (24) @(posedge clk);
        rd(`ASP_REG_STAT, d, 1'b1);
        chk("fifo drained", 16'h50, d);
    endtask

    task automatic t_disable_reset;
        logic [7:0] d;
        int         lows;
        int         k;
        wr(`ASP_REG_FMT, 8'h03, 1'b0);
        wr(`ASP_REG_DATA, 8'h00, 1'b1);
        lows = 0;
        for (k = 0; k < 200; k++)
        begin
            @(posedge clk);
            lows += (ser_out !== 1'b1);
        end
        chk("mark while disabled", 16'h0, 16'(lows));
        wr(`ASP_REG_FMT, 8'h83, 1'b1);
        repeat (40) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("mark in reset", 16'h1, {15'h0, ser_out});
        chk("bus off in reset", 16'h0, {15'h0, doe});
        sys_rst <= 1'b0;
        rd(`ASP_REG_STAT, d, 1'b0);
        chk("status after reset", 16'h50, d);
    endtask

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {cs_a, cs_b, cs_c_n} = 3'b110;
        {rd_hi, rd_n, wr_hi, wr_n} = 4'b0101;
        rsel = 3'h0;
        din = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_select();
        t_tx_len();
        t_stop_parity();
        t_rx();
        t_baud();
        t_fifo();
        t_disable_reset();
        print_verdict();
    end

    // The whole run needs about 9000 cycles.
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule

`default_nettype wire
